// *** sleep_core_model.sv ***
// Model of the core and interrupt sources facing the sleep sequencer.
// Assumes the bench calls its tasks; all drives follow a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module sleep_core_model
    import sleep_wake_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Core side drive
    output logic sleep_instr_o,
    output logic [NUM_SRC-1:0] irq_src_o,
    output logic wdt_wake_o
);
    initial begin
        sleep_instr_o = 1'b0;
        irq_src_o = '0;
        wdt_wake_o = 1'b0;
    end

    // ------------------------------------------------------------------
    // Requests
    // ------------------------------------------------------------------
    // Held a full instruction cycle so exactly one enable slot sees it.
    // The sequencer clears the watchdog itself when each sleep is entered.
    task automatic do_sleep();
        @(posedge sys_clk_i);
        sleep_instr_o <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        sleep_instr_o <= 1'b0;
    endtask

    task automatic pulse_irq(input logic [2:0] idx);
        @(posedge sys_clk_i);
        irq_src_o[idx] <= 1'b1;
        @(posedge sys_clk_i);
        irq_src_o <= '0;
    endtask

    task automatic wake_wdt();
        @(posedge sys_clk_i);
        wdt_wake_o <= 1'b1;
        @(posedge sys_clk_i);
        wdt_wake_o <= 1'b0;
    endtask
endmodule // sleep_core_model

`default_nettype wire

// *** sleep_wake.sv ***
// Sleep entry and interrupt wake-up sequencer with an APB register file.
// Assumes interrupt sources, the sleep request and the watchdog wake come
// from logic on sys_clk_i; the core honours exec_hold_o/dummy_o.
`timescale 1ns/1ps
`default_nettype none

module sleep_wake
    import sleep_wake_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Core side
    input wire logic sleep_instr_i,
    input wire logic [NUM_SRC-1:0] irq_src_i,
    input wire logic wdt_wake_i,
    output logic wdt_clear_o,
    output logic osc_off_o,
    output logic exec_hold_o,
    output logic dummy_o,
    output logic vector_o,
    output logic [12:0] vector_addr_o,
    // Interrupt
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Instruction-cycle enable
    // ------------------------------------------------------------------
    logic [1:0] qph_q, qph_d;
    logic instr_ce;

    always_comb begin
        qph_d = qph_q + 2'h1;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            qph_q <= 2'h0;
        end else begin
            qph_q <= qph_d;
        end
    end

    assign instr_ce = (qph_q == 2'(Q_PER_INSTR - 1));

    // ------------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------------
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [7:0] irq_en_q, irq_en_d, irq_flag_q, irq_flag_d;
    logic [2:0] evt_q, evt_d, evt_mask_q, evt_mask_d, evt_set;
    logic irq_q, irq_d;
    logic tmo_q, tmo_d, pwrdn_q, pwrdn_d;
    state_t st_q, st_d;
    logic wr_en, pend, glb_en, xtal;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_IRQ_EN) ||
                 (a == OFS_IRQ_FLAG) || (a == OFS_PWR_STAT) ||
                 (a == OFS_EVT_STAT) || (a == OFS_EVT_MASK);
    endfunction

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_en && (paddr_i == a);
    endfunction

    // Writes land at the edge where pready is seen high
    assign wr_en = psel_i && penable_i && pwrite_i && pready_q;
    assign glb_en = ctrl_q[CTRL_GLOBAL_EN_BIT];
    assign xtal = (ctrl_q[CTRL_OSC_LSB +: 2] != OSC_RC);
    // Global enable is deliberately not part of the wake condition
    assign pend = |(irq_en_q & irq_flag_q);

    always_comb begin
        pready_d = psel_i && penable_i && !pready_q;
        pslverr_d = pready_d && !mapped(paddr_i);
        prdata_d = prdata_q;
        if (pready_d) begin
            prdata_d = 32'h0000_0000;
            case (paddr_i)
                OFS_CTRL: prdata_d[2:0] = ctrl_q;
                OFS_IRQ_EN: prdata_d[7:0] = irq_en_q;
                OFS_IRQ_FLAG: prdata_d[7:0] = irq_flag_q;
                OFS_PWR_STAT: begin
                    prdata_d[PWR_TIMEOUT_BIT] = tmo_q;
                    prdata_d[PWR_POWERDOWN_BIT] = pwrdn_q;
                    prdata_d[PWR_STATE_LSB +: 3] = st_q;
                end
                OFS_EVT_STAT: prdata_d[2:0] = evt_q;
                OFS_EVT_MASK: prdata_d[2:0] = evt_mask_q;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        ctrl_d = wr_hit(OFS_CTRL) ? pwdata_i[2:0] : ctrl_q;
        irq_en_d = wr_hit(OFS_IRQ_EN) ? pwdata_i[7:0] : irq_en_q;
        evt_mask_d = wr_hit(OFS_EVT_MASK) ? pwdata_i[2:0] : evt_mask_q;
        // A source pulse in the clearing cycle survives the clear
        irq_flag_d = irq_flag_q | irq_src_i;
        if (wr_hit(OFS_IRQ_FLAG)) begin
            irq_flag_d = (irq_flag_q & ~pwdata_i[7:0]) | irq_src_i;
        end
        evt_d = evt_q | evt_set;
        if (wr_hit(OFS_EVT_STAT)) begin
            evt_d = (evt_q & ~pwdata_i[2:0]) | evt_set;
        end
        irq_d = |(evt_d & evt_mask_d);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_q <= CTRL_RST;
            irq_en_q <= IRQ_EN_RST;
            irq_flag_q <= 8'h00;
            evt_q <= 3'h0;
            evt_mask_q <= EVT_MASK_RST;
            irq_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            ctrl_q <= ctrl_d;
            irq_en_q <= irq_en_d;
            irq_flag_q <= irq_flag_d;
            evt_q <= evt_d;
            evt_mask_q <= evt_mask_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Sleep sequencer
    // ------------------------------------------------------------------
    logic [10:0] cnt_q, cnt_d;
    logic wclr_q, wclr_d, vec_q, vec_d;
    logic hold_q, hold_d, dmy_q, dmy_d, osc_q, osc_d;
    logic [12:0] vaddr_q, vaddr_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        tmo_d = tmo_q;
        pwrdn_d = pwrdn_q;
        wclr_d = 1'b0;
        vec_d = 1'b0;
        vaddr_d = vaddr_q;
        evt_set = 3'h0;
        case (st_q)
            ST_AWAKE: begin
                if (instr_ce && sleep_instr_i) begin
                    if (pend) begin
                        // Completes as a no-op; flags and watchdog kept
                        evt_set[EVT_NOOP] = 1'b1;
                    end else begin
                        // Side effects land with the entry itself
                        wclr_d = 1'b1;
                        tmo_d = 1'b1;
                        pwrdn_d = 1'b0;
                        st_d = ST_SLEEP;
                        evt_set[EVT_SLEPT] = 1'b1;
                    end
                end
            end
            ST_SLEEP: begin
                // No wait for the instruction phase: wake is immediate
                if (pend || wdt_wake_i) begin
                    wclr_d = 1'b1;
                    if (wdt_wake_i && !pend) begin
                        tmo_d = 1'b0;
                    end
                    evt_set[EVT_WOKE] = 1'b1;
                    if (xtal) begin
                        st_d = ST_OST;
                        cnt_d = 11'(OST_CYCLES - 1);
                    end else begin
                        st_d = ST_NEXT;
                    end
                end
            end
            ST_OST: begin
                if (cnt_q == 11'h000) begin
                    st_d = ST_NEXT;
                end else begin
                    cnt_d = cnt_q - 11'h001;
                end
            end
            ST_NEXT: begin
                // The prefetched instruction runs during this cycle
                if (instr_ce) begin
                    if (glb_en && pend) begin
                        st_d = ST_DUMMY;
                        cnt_d = 11'(DUMMY_INSTR - 1);
                    end else begin
                        st_d = ST_AWAKE;
                    end
                end
            end
            ST_DUMMY: begin
                if (instr_ce) begin
                    if (cnt_q == 11'h000) begin
                        st_d = ST_AWAKE;
                        vec_d = 1'b1;
                        vaddr_d = VECTOR_ADDR;
                    end else begin
                        cnt_d = cnt_q - 11'h001;
                    end
                end
            end
            default: st_d = ST_AWAKE;
        endcase
        hold_d = (st_d == ST_SLEEP) || (st_d == ST_OST) ||
                 (st_d == ST_DUMMY);
        dmy_d = (st_d == ST_DUMMY);
        // Oscillator stays off until the start-up wait begins
        osc_d = (st_d == ST_SLEEP);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ST_AWAKE;
            cnt_q <= 11'h000;
            tmo_q <= TIMEOUT_RST;
            pwrdn_q <= POWERDOWN_RST;
            wclr_q <= 1'b0;
            vec_q <= 1'b0;
            vaddr_q <= 13'h0000;
            hold_q <= 1'b0;
            dmy_q <= 1'b0;
            osc_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            tmo_q <= tmo_d;
            pwrdn_q <= pwrdn_d;
            wclr_q <= wclr_d;
            vec_q <= vec_d;
            vaddr_q <= vaddr_d;
            hold_q <= hold_d;
            dmy_q <= dmy_d;
            osc_q <= osc_d;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign wdt_clear_o = wclr_q;
    assign osc_off_o = osc_q;
    assign exec_hold_o = hold_q;
    assign dummy_o = dmy_q;
    assign vector_o = vec_q;
    assign vector_addr_o = vaddr_q;
    assign irq_o = irq_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [10:0] ost_run_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ost_run_q <= 11'h000;
        end else begin
            ost_run_q <= (st_q == ST_OST) ? ost_run_q + 11'h001 : 11'h000;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic sleep_req;
    assign sleep_req = (st_q == ST_AWAKE) && instr_ce && sleep_instr_i;

    AST_NOOP_STAYS_AWAKE: assert property (
        sleep_req && pend |=> st_q == ST_AWAKE && !exec_hold_o)
        else $error("no-op sleep entered sleep");
    AST_NOOP_KEEPS_FLAGS: assert property (
        sleep_req && pend |=>
            !wdt_clear_o && $stable(pwrdn_q) && $stable(tmo_q))
        else $error("no-op sleep touched watchdog or flags");
    AST_SLEEP_EFFECTS: assert property (
        sleep_req && !pend |=>
            wdt_clear_o && tmo_q && !pwrdn_q && osc_off_o)
        else $error("sleep entry side effects missing");
    AST_DONE_BEFORE_WAKE: assert property (
        $rose(st_q == ST_SLEEP) |-> wdt_clear_o && !pwrdn_q && tmo_q)
        else $error("sleep not complete at entry");
    AST_WAKE_AT_ONCE: assert property (
        st_q == ST_SLEEP && pend |=> st_q != ST_SLEEP && !osc_off_o)
        else $error("pending interrupt did not wake at once");
    AST_WAKE_CLEARS_WDT: assert property (
        st_q == ST_SLEEP && (pend || wdt_wake_i) |=> wdt_clear_o)
        else $error("wake-up without watchdog clear");
    AST_OST_LENGTH: assert property (
        st_q == ST_OST && st_d != ST_OST |->
            ost_run_q == 11'(OST_CYCLES - 1))
        else $error("start-up wait has wrong length");
    AST_INLINE_NO_GLOBAL: assert property (
        st_q == ST_NEXT && instr_ce && !glb_en |=>
            st_q == ST_AWAKE && !vector_o && !dummy_o)
        else $error("in-line wake took a branch");
    AST_DUMMY_THEN_VECTOR: assert property (
        st_q == ST_NEXT && instr_ce && glb_en && pend |=>
            dummy_o [*8] ##1 (vector_o && !dummy_o))
        else $error("dummy cycles or vector branch wrong");
    AST_VECTOR_ADDR: assert property (
        vector_o |-> vector_addr_o == VECTOR_ADDR && $past(dummy_o))
        else $error("vector branch to wrong address");

    COV_NOOP_SLEEP: cover property (sleep_req && pend);
    COV_VECTOR_WAKE: cover property (vector_o);
    COV_INLINE_WAKE: cover property (st_q == ST_NEXT && instr_ce && !glb_en);
    COV_WDT_WAKE: cover property (st_q == ST_SLEEP && wdt_wake_i);

endmodule // sleep_wake

`default_nettype wire

// *** sleep_wake_pkg.sv ***
// Constants, register map and types of the sleep and wake-up sequencer.
// Assumes one 250 MHz system clock that also stands for the oscillator.
package sleep_wake_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN = 8'h04;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h08;
    localparam logic [7:0] OFS_PWR_STAT = 8'h0C;
    localparam logic [7:0] OFS_EVT_STAT = 8'h10;
    localparam logic [7:0] OFS_EVT_MASK = 8'h14;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned NUM_SRC = 8;
    localparam int unsigned CTRL_GLOBAL_EN_BIT = 0;
    localparam int unsigned CTRL_OSC_LSB = 1;
    localparam int unsigned PWR_TIMEOUT_BIT = 0;
    localparam int unsigned PWR_POWERDOWN_BIT = 1;
    localparam int unsigned PWR_STATE_LSB = 2;
    localparam int unsigned EVT_SLEPT = 0;
    localparam int unsigned EVT_NOOP = 1;
    localparam int unsigned EVT_WOKE = 2;
    localparam int unsigned NUM_EVT = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [2:0] EVT_MASK_RST = 3'h0;
    localparam logic TIMEOUT_RST = 1'b1;
    localparam logic POWERDOWN_RST = 1'b1;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned TOSC_PS = 4000;
    localparam int unsigned OST_TOSC = 1024;
    localparam int unsigned OST_CYCLES =
        (OST_TOSC * TOSC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned Q_PER_INSTR = 4;
    localparam int unsigned DUMMY_INSTR = 2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OSC_RC, OSC_XTAL_STD, OSC_XTAL_FAST, OSC_XTAL_SLOW
    } osc_mode_t;

    typedef enum logic [2:0] {
        ST_AWAKE, ST_SLEEP, ST_OST, ST_NEXT, ST_DUMMY
    } state_t;

endpackage

// *** sleep_wake_tb_top.sv ***
// Self-checking bench of the sleep and wake-up sequencer.
// Assumes the sequencer's APB timing and registers as handed over.
`timescale 1ns/1ps
`default_nettype none

module sleep_wake_tb_top;
    import sleep_wake_pkg::*;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, sleep_instr, wdt_wake;
    logic [NUM_SRC-1:0] irq_src;
    logic wdt_clear, osc_off, exec_hold, dummy, vector, irq;
    logic [12:0] vector_addr, vec_addr;
    int fail_count = 0, n_compared = 0, cycles = 0, exp_clr = 0, k;
    int clr_cnt = 0, vec_cnt = 0, dummy_cnt = 0, hold_cnt = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    sleep_wake sleep_wake_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .sleep_instr_i(sleep_instr), .irq_src_i(irq_src),
        .wdt_wake_i(wdt_wake), .wdt_clear_o(wdt_clear),
        .osc_off_o(osc_off), .exec_hold_o(exec_hold), .dummy_o(dummy),
        .vector_o(vector), .vector_addr_o(vector_addr), .irq_o(irq));

    sleep_core_model sleep_core_model_i (.sys_clk_i(sys_clk_i),
        .sleep_instr_o(sleep_instr), .irq_src_o(irq_src),
        .wdt_wake_o(wdt_wake));

    // ------------------------------------------------------------------
    // Monitors and hang guard
    // ------------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        cycles++;
        if (wdt_clear === 1'b1) clr_cnt++;
        if (dummy === 1'b1) dummy_cnt++;
        if (exec_hold === 1'b1 && osc_off === 1'b0 && dummy === 1'b0)
            hold_cnt++;
        if (vector === 1'b1) begin
            vec_cnt++;
            vec_addr = vector_addr;
        end
        if (cycles >= 20000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge sys_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready !== 1'b1) @(posedge sys_clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask

    // Counts one more watchdog clear pulse within the given cycle budget
    task automatic wait_clr(input int limit);
        exp_clr++;
        for (k = 0; k < limit && clr_cnt < exp_clr; k++) @(posedge sys_clk_i);
        check("watchdog clear pulses", clr_cnt, exp_clr);
    endtask

    task automatic wait_awake();
        for (k = 0; k < 300; k++) begin
            apb(1'b0, OFS_PWR_STAT, 32'h0000_0000);
            if (rd[4:2] === 3'h0) break;
        end
        check("state awake", {29'h0, rd[4:2]}, 32'h0000_0000);
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        // Reset values, read-only status and an unmapped word
        rd_chk("ctrl reset", OFS_CTRL, 32'h0000_0000);
        rd_chk("irq enable reset", OFS_IRQ_EN, 32'h0000_0000);
        rd_chk("power status reset", OFS_PWR_STAT, 32'h0000_0003);
        apb(1'b1, OFS_PWR_STAT, 32'h0000_0000);
        rd_chk("power status read only", OFS_PWR_STAT, 32'h0000_0003);
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("unmapped error", {31'h0, err}, 32'h0000_0001);
        // Pending enabled flag before sleep: sleep becomes a no-op
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0009);
        sleep_core_model_i.pulse_irq(3'h0);
        rd_chk("irq flag set", OFS_IRQ_FLAG, 32'h0000_0001);
        sleep_core_model_i.do_sleep();
        repeat (8) @(posedge sys_clk_i);
        check("no-op leaves watchdog", clr_cnt, 32'h0000_0000);
        rd_chk("no-op flags", OFS_PWR_STAT, 32'h0000_0003);
        rd_chk("no-op event", OFS_EVT_STAT, 32'h0000_0002);
        apb(1'b1, OFS_IRQ_FLAG, 32'h0000_00FF);
        apb(1'b1, OFS_EVT_STAT, 32'h0000_0007);
        // Real sleep in internal oscillator mode, global enable off
        apb(1'b1, OFS_EVT_MASK, 32'h0000_0001);
        sleep_core_model_i.do_sleep();
        wait_clr(8);
        rd_chk("sleep flags", OFS_PWR_STAT, 32'h0000_0005);
        check("slept interrupt", {31'h0, irq}, 32'h0000_0001);
        check("oscillator off", {31'h0, osc_off}, 32'h0000_0001);
        check("sleep holds core", {31'h0, exec_hold}, 32'h0000_0001);
        sleep_core_model_i.pulse_irq(3'h3);
        wait_clr(4);
        wait_awake();
        check("in-line no vector", vec_cnt, 32'h0000_0000);
        check("no start-up wait", hold_cnt, 32'h0000_0000);
        rd_chk("after wake flags", OFS_PWR_STAT, 32'h0000_0001);
        // Status interrupt masked, unmasked, then cleared
        apb(1'b1, OFS_EVT_MASK, 32'h0000_0000);
        repeat (2) @(posedge sys_clk_i);
        check("masked interrupt", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, OFS_EVT_MASK, 32'h0000_0005);
        repeat (2) @(posedge sys_clk_i);
        check("unmasked interrupt", {31'h0, irq}, 32'h0000_0001);
        apb(1'b1, OFS_EVT_STAT, 32'h0000_0007);
        repeat (2) @(posedge sys_clk_i);
        check("cleared interrupt", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, OFS_IRQ_FLAG, 32'h0000_00FF);
        // Watchdog wake clears the time-out flag
        sleep_core_model_i.do_sleep();
        wait_clr(8);
        sleep_core_model_i.wake_wdt();
        wait_clr(4);
        wait_awake();
        rd_chk("watchdog wake flags", OFS_PWR_STAT, 32'h0000_0000);
        // Every crystal mode with global enable on: wait, dummies, vector
        for (int m = 1; m <= 3; m++) begin
            apb(1'b1, OFS_CTRL, 32'(m * 2 + 1));
            hold_cnt = 0;
            dummy_cnt = 0;
            sleep_core_model_i.do_sleep();
            wait_clr(8);
            sleep_core_model_i.pulse_irq(3'h0);
            wait_clr(4);
            for (k = 0; k < 2000 && vec_cnt < m; k++) @(posedge sys_clk_i);
            check("vector count", vec_cnt, 32'(m));
            check("vector address", {19'h0, vec_addr}, 32'h0000_0004);
            check("start-up wait", hold_cnt, OST_CYCLES);
            check("dummy cycles", dummy_cnt, 32'h0000_0008);
            apb(1'b1, OFS_IRQ_FLAG, 32'h0000_00FF);
            wait_awake();
        end
        stop_test();
    end
endmodule // sleep_wake_tb_top

`default_nettype wire
